/* include/seg_walk_pkg.sv */
// Purpose: shared constants and types for the segment table walker
// Assumes: 64-bit effective and physical addresses, big-endian bit numbering in entries
// Notes: entry doubleword 0 sits in the upper 64 bits of a 128-bit memory word
// ----------------------------------------------------------------
// package
// ----------------------------------------------------------------
package seg_walk_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_BASE_LO = 8'h04;
  localparam logic [7:0] OFF_BASE_HI = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0c;
  localparam int CTRL_SLB_EN_POS = 0;
  localparam int CTRL_BRIDGE_POS = 1;
  localparam logic CTRL_SLB_EN_RST = 1'b1;
  localparam logic CTRL_BRIDGE_RST = 1'b0;
  localparam logic [51:0] BASE_RST = 52'h0_0000_0000_0000;
  localparam int STAT_BUSY_POS = 0;
  localparam int STAT_FAULT_POS = 1;
  localparam int STAT_STALL_POS = 2;
  localparam int STAT_WALKS_POS = 8;
  localparam int STAT_FAULTS_POS = 16;
  // ----------------------------------------------------------------
  // entry layout
  // ----------------------------------------------------------------
  localparam int ENTRY_W = 128;
  localparam int EFFECTIVE_SEGMENT_ID_W = 36;
  localparam int HASH_W = 5;
  localparam int EFFECTIVE_SEGMENT_ID_MSB = 127;
  localparam int VALID_POS = 71;
  localparam int SELECT_POS = 70;
  localparam int EA_EFFECTIVE_SEGMENT_ID_LSB = 28;
  localparam int ENTRIES_PER_GROUP = 8;
  localparam int BRIDGE_RESERVED = 16;
  // ----------------------------------------------------------------
  // memory attributes
  // ----------------------------------------------------------------
  localparam logic [3:0] WALK_ATTR_BITS = 4'h2;
  localparam logic [2:0] WALK_ATTR_TRIPLE = 3'h1;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int INVAL_TIME_NS = 40;
  localparam int INVAL_CYCLES = (INVAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ----------------------------------------------------------------
  // walk states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    WALK_IDLE = 2'b00,
    WALK_ISSUE = 2'b01,
    WALK_WAIT = 2'b10
  } walk_state_t;
endpackage : seg_walk_pkg

/* hw/ste_match.sv */
// Purpose: compare one segment table entry against the faulting segment
// Assumes: entry as read from memory, doubleword 0 in the upper half
// Notes: purely combinational
`timescale 1ns/1ps
module ste_match
  import seg_walk_pkg::*;
(
  input wire logic [seg_walk_pkg::ENTRY_W-1:0] entry,
  input wire logic [seg_walk_pkg::EFFECTIVE_SEGMENT_ID_W-1:0] effective_segment_id,
  output logic hit,
  output logic direct_store
);
  // ----------------------------------------------------------------
  // match
  // ----------------------------------------------------------------
  logic valid;
  logic [EFFECTIVE_SEGMENT_ID_W-1:0] entry_effective_segment_id;
  assign valid = entry[VALID_POS];
  assign entry_effective_segment_id = entry[EFFECTIVE_SEGMENT_ID_MSB -: EFFECTIVE_SEGMENT_ID_W];
  assign hit = valid && (entry_effective_segment_id == effective_segment_id);
  assign direct_store = entry[SELECT_POS];
endmodule : ste_match

/* hw/segment_table_walker.sv */
// Purpose: hardware segment table walk on a lookaside buffer miss
// Assumes: pipeline, memory port and register port all on core_clk
// Notes: one entry read outstanding at a time, stops on the first hit
//
// Our own choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
module segment_table_walker
  import seg_walk_pkg::*;
#(
  parameter int SLB_ENTRIES = 64,
  parameter int IDX_W = $clog2(SLB_ENTRIES)
)
(
  input wire logic core_clk,
  input wire logic rst_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // miss request from translation
  input wire logic miss_valid,
  input wire logic [63:0] miss_effective_address,
  input wire logic miss_instr,
  output logic miss_ready,
  // memory read port
  output logic mem_req_valid,
  output logic [63:0] mem_req_addr,
  output logic [3:0] mem_req_storage_attribute_bits,
  output logic [2:0] mem_req_storage_attribute_triple,
  input wire logic mem_req_ready,
  input wire logic mem_rsp_valid,
  input wire logic [seg_walk_pkg::ENTRY_W-1:0] mem_rsp_data,
  // outcome to translation and buffer
  output logic slb_fill_valid,
  output logic [seg_walk_pkg::ENTRY_W-1:0] slb_fill_entry,
  output logic [IDX_W-1:0] slb_fill_index,
  output logic slb_fill_direct_store,
  output logic walk_done,
  output logic instruction_storage_fault,
  output logic data_storage_fault,
  // buffer invalidation and barrier
  input wire logic slb_inval_req,
  input wire logic sync_req,
  output logic slb_inval_active,
  output logic sync_stall,
  output logic sync_done,
  // segment routing
  input wire logic xlate_valid,
  input wire logic xlate_enable,
  input wire logic xlate_block_translation_area_hit,
  input wire logic xlate_select,
  output logic route_direct_store,
  output logic route_memory
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  localparam int CNT_W = $clog2(INVAL_CYCLES + 1);
  localparam logic [CNT_W-1:0] INVAL_LOAD = CNT_W'(INVAL_CYCLES);
  localparam logic [IDX_W-1:0] RESERVED_LOAD = IDX_W'(BRIDGE_RESERVED);
  localparam logic [2:0] LAST_IDX = 3'(ENTRIES_PER_GROUP - 1);

  typedef struct packed {
    walk_state_t st;
    logic [63:0] ea;
    logic instr;
    logic grp;
    logic [2:0] idx;
    logic [63:0] prim_addr;
    logic [63:0] sec_addr;
    logic miss_ready;
    logic mem_req_valid;
    logic [63:0] mem_req_addr;
    logic fill_valid;
    logic [ENTRY_W-1:0] fill_entry;
    logic [IDX_W-1:0] fill_index;
    logic fill_ds;
    logic walk_done;
    logic fault_i;
    logic fault_d;
    logic last_fault;
    logic [IDX_W-1:0] rr;
    logic slb_en;
    logic bridge;
    logic [51:0] base;
    logic [31:0] rdata;
    logic [7:0] walks;
    logic [7:0] faults;
    logic [CNT_W-1:0] inval_cnt;
    logic inval_active;
    logic sync_pend;
    logic sync_done;
    logic route_ds;
    logic route_mem;
  } walker_regs_t;

  walker_regs_t r;
  walker_regs_t next_r;
  logic rsp_hit;
  logic rsp_ds;

  // ----------------------------------------------------------------
  // entry compare
  // ----------------------------------------------------------------
  ste_match u_match (
    .entry(mem_rsp_data),
    .effective_segment_id(r.ea[63 -: EFFECTIVE_SEGMENT_ID_W]),
    .hit(rsp_hit),
    .direct_store(rsp_ds)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [63:0] group_addr(input logic [51:0] base, input logic [HASH_W-1:0] hash);
    group_addr = {base, hash, 7'h00};
  endfunction : group_addr

  function automatic logic [63:0] entry_addr(input logic [63:0] grp_base, input logic [2:0] idx);
    entry_addr = {grp_base[63:7], idx, 4'h0};
  endfunction : entry_addr

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [HASH_W-1:0] hash1;
    logic [IDX_W-1:0] victim;
    logic inval_busy;
    hash1 = '0;
    victim = '0;
    inval_busy = 1'b0;
    next_r = r;
    next_r.fill_valid = 1'b0;
    next_r.walk_done = 1'b0;
    next_r.fault_i = 1'b0;
    next_r.fault_d = 1'b0;
    next_r.sync_done = 1'b0;
    next_r.rdata = 32'h0000_0000;

    // register writes
    if (reg_wr)
    begin
      if (reg_addr == OFF_CTRL)
      begin
        next_r.slb_en = reg_wdata[CTRL_SLB_EN_POS];
        next_r.bridge = reg_wdata[CTRL_BRIDGE_POS];
      end
      if (reg_addr == OFF_BASE_LO)
      begin
        next_r.base[19:0] = reg_wdata[31:12];
      end
      if (reg_addr == OFF_BASE_HI)
      begin
        next_r.base[51:20] = reg_wdata;
      end
    end

    // register reads, unmapped reads zero
    if (reg_rd)
    begin
      unique case (reg_addr)
        OFF_CTRL:
        begin
          next_r.rdata[CTRL_SLB_EN_POS] = r.slb_en;
          next_r.rdata[CTRL_BRIDGE_POS] = r.bridge;
        end
        OFF_BASE_LO: next_r.rdata = {r.base[19:0], 12'h000};
        OFF_BASE_HI: next_r.rdata = r.base[51:20];
        OFF_STATUS:
        begin
          next_r.rdata[STAT_BUSY_POS] = (r.st != WALK_IDLE);
          next_r.rdata[STAT_FAULT_POS] = r.last_fault;
          next_r.rdata[STAT_STALL_POS] = r.sync_pend;
          next_r.rdata[STAT_WALKS_POS +: 8] = r.walks;
          next_r.rdata[STAT_FAULTS_POS +: 8] = r.faults;
        end
        default: next_r.rdata = 32'h0000_0000;
      endcase
    end

    // walk
    unique case (r.st)
      WALK_IDLE:
      begin
        if (miss_valid && r.miss_ready)
        begin
          hash1 = miss_effective_address[EA_EFFECTIVE_SEGMENT_ID_LSB +: HASH_W];
          next_r.ea = miss_effective_address;
          next_r.instr = miss_instr;
          next_r.grp = 1'b0;
          next_r.idx = 3'h0;
          next_r.prim_addr = group_addr(r.base, hash1);
          next_r.sec_addr = group_addr(r.base, ~hash1);
          next_r.mem_req_valid = 1'b1;
          next_r.mem_req_addr = entry_addr(group_addr(r.base, hash1), 3'h0);
          next_r.miss_ready = 1'b0;
          next_r.st = WALK_ISSUE;
        end
      end
      WALK_ISSUE:
      begin
        if (mem_req_ready)
        begin
          next_r.mem_req_valid = 1'b0;
          next_r.st = WALK_WAIT;
        end
      end
      WALK_WAIT:
      begin
        if (mem_rsp_valid)
        begin
          if (rsp_hit)
          begin
            // bridge mode keeps the low sixteen slots for the fixed descriptors
            victim = r.bridge ? IDX_W'(r.ea[EA_EFFECTIVE_SEGMENT_ID_LSB +: 4]) : r.rr;
            next_r.fill_valid = r.slb_en;
            next_r.fill_entry = mem_rsp_data;
            next_r.fill_index = victim;
            next_r.fill_ds = rsp_ds;
            next_r.walk_done = 1'b1;
            next_r.last_fault = 1'b0;
            if (r.slb_en)
            begin
              next_r.rr = r.rr + IDX_W'(1);
              // bridge mode wraps past the reserved slots, not to zero
              if (r.bridge && r.rr == IDX_W'(SLB_ENTRIES - 1))
              begin
                next_r.rr = RESERVED_LOAD;
              end
            end
            next_r.walks = r.walks + 8'h01;
            next_r.miss_ready = 1'b1;
            next_r.st = WALK_IDLE;
          end
          else if (r.grp && r.idx == LAST_IDX)
          begin
            next_r.fault_i = r.instr;
            next_r.fault_d = !r.instr;
            next_r.last_fault = 1'b1;
            next_r.walks = r.walks + 8'h01;
            next_r.faults = r.faults + 8'h01;
            next_r.miss_ready = 1'b1;
            next_r.st = WALK_IDLE;
          end
          else
          begin
            // primary group first, then secondary, sixteen reads at most
            if (r.idx == LAST_IDX)
            begin
              next_r.grp = 1'b1;
              next_r.idx = 3'h0;
              next_r.mem_req_addr = entry_addr(r.sec_addr, 3'h0);
            end
            else
            begin
              next_r.idx = r.idx + 3'h1;
              next_r.mem_req_addr = entry_addr(r.grp ? r.sec_addr : r.prim_addr, r.idx + 3'h1);
            end
            next_r.mem_req_valid = 1'b1;
            next_r.st = WALK_ISSUE;
          end
        end
      end
      default:
      begin
        next_r.st = WALK_IDLE;
        next_r.mem_req_valid = 1'b0;
        next_r.miss_ready = 1'b1;
      end
    endcase

    // entering bridge mode moves round robin past the reserved slots
    if (!r.bridge && next_r.bridge && r.rr < RESERVED_LOAD)
    begin
      next_r.rr = RESERVED_LOAD;
    end

    // invalidation and barrier
    if (slb_inval_req)
    begin
      next_r.inval_cnt = INVAL_LOAD;
    end
    else if (r.inval_cnt != '0)
    begin
      next_r.inval_cnt = r.inval_cnt - CNT_W'(1);
    end
    inval_busy = slb_inval_req || (next_r.inval_cnt != '0);
    next_r.inval_active = (next_r.inval_cnt != '0);
    if (sync_req || r.sync_pend)
    begin
      next_r.sync_pend = inval_busy;
      next_r.sync_done = !inval_busy;
    end

    // segment routing
    next_r.route_ds = xlate_valid && xlate_enable && !xlate_block_translation_area_hit && xlate_select;
    next_r.route_mem = xlate_valid && xlate_enable && !xlate_block_translation_area_hit && !xlate_select;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      r <= '0;
      r.st <= WALK_IDLE;
      r.miss_ready <= 1'b1;
      r.slb_en <= CTRL_SLB_EN_RST;
      r.bridge <= CTRL_BRIDGE_RST;
      r.base <= BASE_RST;
    end
    else
    begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign reg_rdata = r.rdata;
  assign miss_ready = r.miss_ready;
  assign mem_req_valid = r.mem_req_valid;
  assign mem_req_addr = r.mem_req_addr;
  assign mem_req_storage_attribute_bits = WALK_ATTR_BITS;
  assign mem_req_storage_attribute_triple = WALK_ATTR_TRIPLE;
  assign slb_fill_valid = r.fill_valid;
  assign slb_fill_entry = r.fill_entry;
  assign slb_fill_index = r.fill_index;
  assign slb_fill_direct_store = r.fill_ds;
  assign walk_done = r.walk_done;
  assign instruction_storage_fault = r.fault_i;
  assign data_storage_fault = r.fault_d;
  assign slb_inval_active = r.inval_active;
  assign sync_stall = r.sync_pend;
  assign sync_done = r.sync_done;
  assign route_direct_store = r.route_ds;
  assign route_memory = r.route_mem;
endmodule : segment_table_walker

/* testbench/seg_walk_asserts.sv */
// Purpose: port checks for the segment table walker
// Assumes: one clock, async active-low reset
// Notes: helper flops follow the walk in progress
`timescale 1ns/1ps
module seg_walk_asserts
  import seg_walk_pkg::*;
#(
  parameter int SLB_ENTRIES = 64
)
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic miss_valid,
  input wire logic [63:0] miss_effective_address,
  input wire logic miss_instr,
  input wire logic miss_ready,
  input wire logic mem_req_valid,
  input wire logic [63:0] mem_req_addr,
  input wire logic [3:0] mem_req_storage_attribute_bits,
  input wire logic [2:0] mem_req_storage_attribute_triple,
  input wire logic mem_req_ready,
  input wire logic mem_rsp_valid,
  input wire logic [seg_walk_pkg::ENTRY_W-1:0] mem_rsp_data,
  input wire logic walk_done,
  input wire logic instruction_storage_fault,
  input wire logic data_storage_fault,
  input wire logic slb_inval_req,
  input wire logic slb_inval_active,
  input wire logic sync_req,
  input wire logic sync_done,
  input wire logic xlate_valid,
  input wire logic xlate_enable,
  input wire logic xlate_block_translation_area_hit,
  input wire logic xlate_select,
  input wire logic route_direct_store
);
  logic [63:0] ea_q;
  logic instr_q;
  logic [4:0] reads;
  logic is_hit;
  assign is_hit = mem_rsp_data[VALID_POS] && mem_rsp_data[127:92] == ea_q[63:28];
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ea_q <= 64'h0;
      instr_q <= 1'b0;
      reads <= 5'h0;
    end
    else if (miss_valid && miss_ready)
    begin
      ea_q <= miss_effective_address;
      instr_q <= miss_instr;
      reads <= 5'h0;
    end
    else if (mem_req_valid && mem_req_ready)
      reads <= reads + 5'h1;
  end
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  chk_attr_bits: assert property (mem_req_valid |-> mem_req_storage_attribute_bits == 4'h2)
    else $error("walk read attribute bits wrong");
  chk_attr_triple: assert property (mem_req_valid |-> mem_req_storage_attribute_triple == 3'h1)
    else $error("walk read attribute triple wrong");
  chk_first_group: assert property (miss_valid && miss_ready |=> mem_req_valid &&
    mem_req_addr[11:0] == {$past(miss_effective_address[32:28]), 7'h0}) else $error("first group address wrong");
  chk_req_hold: assert property (mem_req_valid && !mem_req_ready |=> mem_req_valid && $stable(mem_req_addr))
    else $error("read request dropped before accept");
  chk_read_limit: assert property (reads <= 5'd16)
    else $error("more than sixteen entry reads");
  chk_fault_count: assert property (instruction_storage_fault || data_storage_fault |-> reads == 5'd16)
    else $error("fault before all entries read");
  chk_fault_side: assert property (instruction_storage_fault || data_storage_fault |->
    instruction_storage_fault == instr_q && data_storage_fault == !instr_q) else $error("fault side wrong");
  chk_hit_done: assert property (mem_rsp_valid && is_hit |=> walk_done)
    else $error("hit not completed");
  chk_one_outcome: assert property (walk_done || instruction_storage_fault || data_storage_fault |->
    $onehot({walk_done, instruction_storage_fault, data_storage_fault}) && !$past(miss_ready))
    else $error("outcome not single or without walk");
  chk_route_ds: assert property (xlate_valid && xlate_enable && !xlate_block_translation_area_hit && xlate_select
    |=> route_direct_store) else $error("direct-store route missing");
  chk_sync_free: assert property (sync_req && !slb_inval_active && !slb_inval_req |=> sync_done)
    else $error("barrier not done at once");
  chk_sync_wait: assert property (slb_inval_active |-> !sync_done)
    else $error("barrier done during invalidation");
endmodule : seg_walk_asserts
bind segment_table_walker seg_walk_asserts #(.SLB_ENTRIES(SLB_ENTRIES)) seg_walk_asserts_inst (.*);

/* testbench/seg_table_mem.sv */
// Purpose: system memory holding one segment table entry
// Assumes: one read outstanding
// Notes: other addresses return entries with valid clear
`timescale 1ns/1ps
module seg_table_mem
  import seg_walk_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic slow,
  input wire logic [63:0] hit_addr,
  input wire logic [seg_walk_pkg::ENTRY_W-1:0] hit_entry,
  input wire logic mem_req_valid,
  input wire logic [63:0] mem_req_addr,
  output logic mem_req_ready,
  output logic mem_rsp_valid,
  output logic [seg_walk_pkg::ENTRY_W-1:0] mem_rsp_data,
  output logic [7:0] reads,
  output logic [63:0] last_addr
);
  logic pend;
  logic [1:0] wait_cnt;
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mem_req_ready <= 1'b0;
      mem_rsp_valid <= 1'b0;
      mem_rsp_data <= '0;
      reads <= 8'h0;
      last_addr <= 64'h0;
      pend <= 1'b0;
      wait_cnt <= 2'h0;
    end
    else
    begin
      mem_req_ready <= slow ? ~mem_req_ready : 1'b1;
      mem_rsp_valid <= 1'b0;
      // idle data flips so stale values are never held steady between responses
      mem_rsp_data <= ~mem_rsp_data;
      if (mem_req_valid && mem_req_ready)
      begin
        reads <= reads + 8'h1;
        last_addr <= mem_req_addr;
        pend <= 1'b1;
        wait_cnt <= slow ? 2'h3 : 2'h0;
      end
      else if (pend && wait_cnt != 2'h0)
        wait_cnt <= wait_cnt - 2'h1;
      else if (pend)
      begin
        pend <= 1'b0;
        mem_rsp_valid <= 1'b1;
        // single whole entry, never half written
        mem_rsp_data <= last_addr == hit_addr ? hit_entry : {last_addr, last_addr} & ~(128'h1 << VALID_POS);
      end
    end
  end
endmodule : seg_table_mem

/* testbench/segment_table_walker_test.sv */
// Purpose: directed checks of the segment table walker
// Assumes: table base 0x00005c8042a17000
// Notes: outputs read just after an edge show the prior cycle
`timescale 1ns/1ps
module segment_table_walker_test;
  import seg_walk_pkg::*;
  localparam logic [51:0] BASE = 52'h00005c8042a17;
  localparam logic [63:0] EA = 64'h0000_0000_9abc_def0;
  localparam logic [127:0] ENT = {36'h0_0000_0009, 20'h0, 8'hc0, 64'hdead_beef_0123_4567};
  logic core_clk, rst_n, reg_wr, reg_rd, miss_valid, miss_instr, miss_ready, mem_req_valid, mem_req_ready;
  logic mem_rsp_valid, slb_fill_valid, slb_fill_direct_store, walk_done, instruction_storage_fault;
  logic data_storage_fault, slb_inval_req, sync_req, slb_inval_active, sync_stall, sync_done, xlate_valid;
  logic xlate_enable, xlate_block_translation_area_hit, xlate_select, route_direct_store, route_memory, slow, st;
  logic [7:0] reg_addr, reads, r0;
  logic [31:0] reg_wdata, reg_rdata, d;
  logic [63:0] miss_effective_address, mem_req_addr, hit_addr, last_addr;
  logic [3:0] mem_req_storage_attribute_bits, outc;
  logic [2:0] mem_req_storage_attribute_triple;
  logic [ENTRY_W-1:0] mem_rsp_data, slb_fill_entry, hit_entry;
  logic [5:0] slb_fill_index;
  int bad_count, cmp_count, n;
  segment_table_walker #(.SLB_ENTRIES(64)) segment_table_walker_inst (.*);
  seg_table_mem seg_table_mem_inst (.*);
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  function automatic logic [63:0] grp(input logic sec, input logic [2:0] i);
    return {BASE, EA[32:28] ^ {5{sec}}, i, 4'h0};
  endfunction : grp
  task chk(input string what, input logic [127:0] seen, input logic [127:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[ERR] %s exp %h seen %h", what, exp, seen);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    d = reg_rdata;
  endtask : rd
  task walk(input logic instr, input int nreads, input logic [63:0] last);
    @(posedge core_clk);
    r0 = reads;
    miss_valid <= 1'b1;
    miss_effective_address <= EA;
    miss_instr <= instr;
    n = 0;
    outc = 4'h0;
    @(posedge core_clk);
    chk("miss ready", miss_ready, 1'b1);
    miss_valid <= 1'b0;
    while (outc == 4'h0 && n < 300)
    begin
      @(posedge core_clk);
      n++;
      outc = {slb_fill_valid, instruction_storage_fault, data_storage_fault, walk_done};
    end
    chk("reads", 8'(reads - r0), nreads[7:0]);
    chk("last addr", last_addr, last);
  endtask : walk
  task barrier(input logic inv);
    @(posedge core_clk);
    slb_inval_req <= inv;
    @(posedge core_clk);
    slb_inval_req <= 1'b0;
    sync_req <= 1'b1;
    @(posedge core_clk);
    sync_req <= 1'b0;
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
      if (n == 1)
        st = sync_stall;
    end
    while (sync_done !== 1'b1 && n < 20);
    chk("sync wait", n, inv ? INVAL_CYCLES : 1);
    chk("sync stall", st, inv);
  endtask : barrier
  task final_report;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  initial
  begin
    repeat (20000) @(posedge core_clk);
    bad_count++;
    final_report();
  end
  initial
  begin
    {rst_n, reg_wr, reg_rd, miss_valid, miss_instr, slb_inval_req, sync_req, slow} = 8'h0;
    {xlate_valid, xlate_enable, xlate_block_translation_area_hit, xlate_select} = 4'h0;
    {reg_addr, reg_wdata, miss_effective_address, hit_addr, hit_entry} = '0;
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(8'h00);
    chk("ctrl reset", d, 32'h1);
    rd(8'h10);
    chk("unmapped", d, 32'h0);
    wr(8'h08, 32'h0000_5c80);
    wr(8'h04, 32'h42a1_7000);
    rd(8'h04);
    chk("base low", d, 32'h42a1_7000);
    $display("registers done");
    hit_addr <= grp(1'b0, 3'h3);
    hit_entry <= ENT;
    walk(1'b0, 4, grp(1'b0, 3'h3));
    chk("hit outcome", outc, 4'b1001);
    chk("fill entry", slb_fill_entry, ENT);
    chk("fill select", slb_fill_direct_store, 1'b1);
    $display("primary hit done");
    wr(8'h00, 32'h3);
    slow <= 1'b1;
    hit_addr <= grp(1'b1, 3'h7);
    walk(1'b0, 16, grp(1'b1, 3'h7));
    chk("slow outcome", outc, 4'b1001);
    chk("bridge index", slb_fill_index, 6'h9);
    $display("secondary hit done");
    hit_addr <= grp(1'b0, 3'h0);
    hit_entry <= ENT & ~(128'h1 << 71);
    for (int s = 0; s < 2; s++)
    begin
      walk(s[0], 16, grp(1'b1, 3'h7));
      chk("fault outcome", outc, s ? 4'b0100 : 4'b0010);
    end
    rd(8'h0c);
    chk("status faults", {d[23:16], d[1]}, {8'h2, 1'b1});
    $display("faults done");
    barrier(1'b0);
    barrier(1'b1);
    $display("barrier done");
    for (int i = 0; i < 8; i++)
    begin
      @(posedge core_clk);
      xlate_valid <= 1'b1;
      {xlate_enable, xlate_block_translation_area_hit, xlate_select} <= i[2:0];
      @(posedge core_clk);
      xlate_valid <= 1'b0;
      @(posedge core_clk);
      chk("route ds", route_direct_store, i == 5);
      chk("route mem", route_memory, i == 4);
    end
    $display("routing done");
    final_report();
  end
endmodule : segment_table_walker_test
